// file: rtl/ftc_pkg.sv
// constants, field layout and register map of the frontend timer block
// assumes a single 25 MHz system clock and an AXI4-Lite register master
package ftc_pkg;
    // clock rates in kHz, base tick made by fractional accumulation
    localparam int FTC_SYS_CLK_KHZ = 25000;
    localparam int FTC_CONTACTLESS_INTERFACE_CLK_KHZ = 13560;
    localparam int FTC_ACC_W = 16;
    localparam logic [FTC_ACC_W:0] FTC_ACC_INC = (FTC_ACC_W+1)'(FTC_CONTACTLESS_INTERFACE_CLK_KHZ);
    localparam logic [FTC_ACC_W:0] FTC_ACC_MOD = (FTC_ACC_W+1)'(FTC_SYS_CLK_KHZ);
    // prescaler divides the base tick by 2 << select
    localparam int FTC_DIV_W = 8;
    localparam logic [FTC_DIV_W:0] FTC_DIV_BASE = 9'h002;
    localparam logic [FTC_DIV_W:0] FTC_DIV_ONE = 9'h001;

    // counter width and reset values
    localparam int FTC_CNT_W = 20;
    localparam logic [2:0] FTC_RATE_RST = 3'h0;
    localparam logic FTC_SRC_RST = 1'b0;
    localparam logic FTC_RELOAD_RST = 1'b0;

    // register byte offsets
    localparam logic [7:0] FTC_OFS_CTRL = 8'h00;
    localparam logic [7:0] FTC_OFS_PRESET = 8'h04;
    localparam logic [7:0] FTC_OFS_COUNT = 8'h08;
    localparam logic [7:0] FTC_OFS_STATE = 8'h0c;
    localparam logic [7:0] FTC_OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] FTC_OFS_IRQ_MASK = 8'h14;

    // control, state and interrupt word bit positions
    localparam int FTC_BIT_HALT = 0;
    localparam int FTC_BIT_RELOAD = 1;
    localparam int FTC_BIT_SRC = 2;
    localparam int FTC_BIT_RATE_LO = 3;
    localparam int FTC_BIT_NOW = 6;
    localparam int FTC_BIT_OFF = 7;
    localparam int FTC_BIT_ON = 8;
    localparam int FTC_BIT_RUNNING = 0;
    localparam int FTC_BIT_EXPIRY = 0;

    // bus response codes
    localparam logic [1:0] FTC_RESP_OKAY = 2'h0;
    localparam logic [1:0] FTC_RESP_SLVERR = 2'h2;

    // control fields, packed to match bits 8 down to 1 of the word
    typedef struct packed {
        logic start_on_own_field_on;
        logic start_on_own_field_off;
        logic start_immediately;
        logic [2:0] divided_rate_select;
        logic clock_source_select;
        logic auto_reload_on_expiry;
    } ftc_ctrl_t;

    localparam ftc_ctrl_t FTC_CTRL_RST = '{
        start_on_own_field_on: 1'b0,
        start_on_own_field_off: 1'b0,
        start_immediately: 1'b0,
        divided_rate_select: FTC_RATE_RST,
        clock_source_select: FTC_SRC_RST,
        auto_reload_on_expiry: FTC_RELOAD_RST
    };
endpackage

// file: rtl/ftc_prescaler.sv
// tick enable generator for the frontend timer
// assumes sys_clk_in at the rate set in the package; ticks are enables
`timescale 1ns/1ps
`default_nettype none
module ftc_prescaler
    import ftc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [2:0] rate_sel_in,
    output logic base_tick_out,
    output logic div_tick_out
);
    logic [FTC_ACC_W-1:0] acc_reg; // phase accumulator
    logic [FTC_ACC_W-1:0] acc_next;
    logic [FTC_DIV_W-1:0] div_reg; // counts base ticks
    logic [FTC_DIV_W-1:0] div_next;
    logic [FTC_DIV_W:0] div_mask; // low bits that must all be set
    logic [FTC_ACC_W:0] sum;

    // base tick averages the contactless rate; jitter is one sys cycle,
    // the price of running everything from one clock
    always_comb begin
        sum = {1'b0, acc_reg} + FTC_ACC_INC;
        base_tick_out = (sum >= FTC_ACC_MOD);
        if (base_tick_out) begin
            acc_next = FTC_ACC_W'(sum - FTC_ACC_MOD);
        end else begin
            acc_next = sum[FTC_ACC_W-1:0];
        end
        div_mask = (FTC_DIV_BASE << rate_sel_in) - FTC_DIV_ONE;
        div_tick_out = base_tick_out &&
            ((div_reg & div_mask[FTC_DIV_W-1:0]) == div_mask[FTC_DIV_W-1:0]);
        div_next = base_tick_out ? div_reg + 8'h01 : div_reg;
    end

    // register accumulator and divider
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            acc_reg <= '0;
            div_reg <= '0;
        end else begin
            acc_reg <= acc_next;
            div_reg <= div_next;
        end
    end
endmodule
`default_nettype wire

// file: rtl/ftc_timer.sv
// frontend timer one: clock source, prescaler, reload and start events,
// with its control registers on an AXI4-Lite slave and one interrupt line
// assumes own-field events arrive as one-cycle pulses on sys_clk_in
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ftc_timer
    import ftc_pkg::*;
#(
    parameter int CNT_W = FTC_CNT_W
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // write address channel
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic [2:0] s_axi_awprot_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    // write data channel
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // write response channel
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // read address channel
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic [2:0] s_axi_arprot_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    // read data channel
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // own rf field events from the field control logic
    input wire logic own_field_on_in,
    input wire logic own_field_off_in,
    // to the rest of the timer unit
    output logic timer_tick_out,
    output logic expiry_out,
    output logic irq_out
);
    // write path state
    logic aw_hold_reg; // address captured
    logic aw_hold_next;
    logic [7:0] aw_addr_reg;
    logic [7:0] aw_addr_next;
    logic w_hold_reg; // data captured
    logic w_hold_next;
    logic [31:0] w_data_reg;
    logic [31:0] w_data_next;
    logic [3:0] w_strb_reg;
    logic [3:0] w_strb_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    // read path state
    logic rvalid_reg;
    logic rvalid_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;
    // software-visible registers
    ftc_ctrl_t ctrl_reg;
    ftc_ctrl_t ctrl_next;
    logic [CNT_W-1:0] preset_reg;
    logic [CNT_W-1:0] preset_next;
    logic irq_stat_reg; // sticky expiry flag
    logic irq_stat_next;
    logic irq_mask_reg;
    logic irq_mask_next;
    // timer core state
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic running_reg;
    logic running_next;
    logic expiry_reg;
    logic expiry_next;
    // decoded strobes
    logic do_write; // both halves present, response slot free
    logic wr_ctrl;
    logic wr_preset;
    logic wr_stat;
    logic wr_mask;
    logic wr_hit;
    logic [31:0] wr_word; // strobed write data over old value
    logic [31:0] ctrl_word;
    logic [31:0] old_word;
    logic start_evt;
    logic halt_evt;
    logic base_tick;
    logic div_tick;
    logic tick;
    logic expire_now;

    // merge strobed bytes into the old word
    function automatic logic [31:0] ftc_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // tick generator: base contactless tick and divided tick
    ftc_prescaler u_prescaler (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .rate_sel_in(ctrl_reg.divided_rate_select),
        .base_tick_out(base_tick),
        .div_tick_out(div_tick)
    );

    // bus handshakes are combinational off the holding flags
    assign s_axi_awready_out = !aw_hold_reg;
    assign s_axi_wready_out = !w_hold_reg;
    assign s_axi_arready_out = !rvalid_reg;
    assign s_axi_bvalid_out = bvalid_reg;
    assign s_axi_bresp_out = bresp_reg;
    assign s_axi_rvalid_out = rvalid_reg;
    assign s_axi_rdata_out = rdata_reg;
    assign s_axi_rresp_out = rresp_reg;
    assign expiry_out = expiry_reg;
    assign irq_out = irq_stat_reg & irq_mask_reg;
    assign timer_tick_out = tick & running_reg;

    // control word view, bit 0 and upper bits read as zero
    assign ctrl_word = {23'h000000, ctrl_reg, 1'b0};

    // address decode and strobed merge for the pending write
    always_comb begin
        do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
        wr_ctrl = do_write && (aw_addr_reg == FTC_OFS_CTRL);
        wr_preset = do_write && (aw_addr_reg == FTC_OFS_PRESET);
        wr_stat = do_write && (aw_addr_reg == FTC_OFS_IRQ_STAT);
        wr_mask = do_write && (aw_addr_reg == FTC_OFS_IRQ_MASK);
        // count and state are read-only but answer okay
        wr_hit = wr_ctrl || wr_preset || wr_stat || wr_mask ||
            (aw_addr_reg == FTC_OFS_COUNT) || (aw_addr_reg == FTC_OFS_STATE);
        case (aw_addr_reg)
            FTC_OFS_CTRL: old_word = ctrl_word;
            FTC_OFS_PRESET: old_word = 32'(preset_reg);
            FTC_OFS_IRQ_MASK: old_word = {31'h00000000, irq_mask_reg};
            default: old_word = 32'h00000000;
        endcase
        wr_word = ftc_merge(old_word, w_data_reg, w_strb_reg);
    end

    // next state of the write channel and writable registers
    always_comb begin
        aw_hold_next = aw_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_hold_next = w_hold_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        ctrl_next = ctrl_reg;
        preset_next = preset_reg;
        irq_mask_next = irq_mask_reg;
        // address and data are taken in either order
        if (s_axi_awvalid_in && !aw_hold_reg) begin
            aw_hold_next = 1'b1;
            aw_addr_next = {s_axi_awaddr_in[7:2], 2'b00};
        end
        if (s_axi_wvalid_in && !w_hold_reg) begin
            w_hold_next = 1'b1;
            w_data_next = s_axi_wdata_in;
            w_strb_next = s_axi_wstrb_in;
        end
        if (do_write) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_hit ? FTC_RESP_OKAY : FTC_RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready_in) begin
            bvalid_next = 1'b0;
        end
        if (wr_ctrl) begin
            ctrl_next = ftc_ctrl_t'(wr_word[FTC_BIT_ON:FTC_BIT_RELOAD]);
        end
        if (wr_preset) begin
            preset_next = wr_word[CNT_W-1:0];
        end
        if (wr_mask) begin
            irq_mask_next = wr_word[FTC_BIT_EXPIRY];
        end
    end

    // read channel: data sampled at the address edge
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_arvalid_in && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next = FTC_RESP_OKAY;
            case ({s_axi_araddr_in[7:2], 2'b00})
                FTC_OFS_CTRL: rdata_next = ctrl_word;
                FTC_OFS_PRESET: rdata_next = 32'(preset_reg);
                FTC_OFS_COUNT: rdata_next = 32'(count_reg);
                FTC_OFS_STATE: rdata_next = {31'h00000000, running_reg};
                FTC_OFS_IRQ_STAT: rdata_next = {31'h00000000, irq_stat_reg};
                FTC_OFS_IRQ_MASK: rdata_next = {31'h00000000, irq_mask_reg};
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = FTC_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready_in) begin
            rvalid_next = 1'b0;
        end
    end

    // start and halt events, tick selection
    always_comb begin
        start_evt = wr_ctrl && wr_word[FTC_BIT_NOW];
        if (ctrl_reg.start_on_own_field_on && own_field_on_in) begin
            start_evt = 1'b1;
        end
        if (ctrl_reg.start_on_own_field_off && own_field_off_in) begin
            start_evt = 1'b1;
        end
        // halt is a write-one pulse, reads as zero
        halt_evt = wr_ctrl && wr_word[FTC_BIT_HALT];
        tick = ctrl_reg.clock_source_select ? div_tick : base_tick;
    end

    // timer core: load, count down, expire
    always_comb begin
        count_next = count_reg;
        running_next = running_reg;
        expiry_next = 1'b0;
        expire_now = 1'b0;
        if (halt_evt) begin
            // halt beats any start in the same cycle
            running_next = 1'b0;
        end else if (start_evt) begin
            // restart while running reloads the preset
            count_next = preset_reg;
            running_next = 1'b1;
        end else if (running_reg && tick) begin
            if (count_reg <= CNT_W'(1)) begin
                expire_now = 1'b1;
                expiry_next = 1'b1;
                if (ctrl_reg.auto_reload_on_expiry) begin
                    count_next = preset_reg;
                end else begin
                    count_next = '0;
                    running_next = 1'b0;
                end
            end else begin
                count_next = count_reg - CNT_W'(1);
            end
        end
        // sticky flag: a new expiry beats a clear in the same cycle
        irq_stat_next = irq_stat_reg;
        if (wr_stat && wr_word[FTC_BIT_EXPIRY]) begin
            irq_stat_next = 1'b0;
        end
        if (expire_now) begin
            irq_stat_next = 1'b1;
        end
    end

    // register every group
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_hold_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= FTC_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= FTC_RESP_OKAY;
            ctrl_reg <= FTC_CTRL_RST;
            preset_reg <= '0;
            irq_stat_reg <= 1'b0;
            irq_mask_reg <= 1'b0;
            count_reg <= '0;
            running_reg <= 1'b0;
            expiry_reg <= 1'b0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            aw_addr_reg <= aw_addr_next;
            w_hold_reg <= w_hold_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            ctrl_reg <= ctrl_next;
            preset_reg <= preset_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            count_reg <= count_next;
            running_reg <= running_next;
            expiry_reg <= expiry_next;
        end
    end
endmodule
`default_nettype wire

// file: sim/ftc_field_model.sv
// model of the own rf field control logic
// assumes the bench calls pulse from its main sequence
`timescale 1ns/1ps
`default_nettype none
module ftc_field_model (
    input wire logic clk_in,
    output logic field_on_out,
    output logic field_off_out
);
    // field quiet until the bench asks
    initial begin
        field_on_out = 1'b0;
        field_off_out = 1'b0;
    end
    // one-cycle switch event, after a prompt or slow wait
    task automatic pulse(input logic on);
        repeat ($urandom_range(4, 1)) @(posedge clk_in);
        field_on_out <= on;
        field_off_out <= !on;
        @(posedge clk_in);
        field_on_out <= 1'b0;
        field_off_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: sim/ftc_timer_asserts.sv
// port checker for the frontend timer block
// assumes it is bound onto ftc_timer by the bench top
`timescale 1ns/1ps
`default_nettype none
module ftc_timer_asserts (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic timer_tick_out,
    input wire logic expiry_out,
    input wire logic irq_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // both write halves taken at one edge, nothing pending
    sequence s_w_both;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
            && s_axi_wready_out && !s_axi_bvalid_out;
    endsequence
    // two timer ticks back to back
    sequence s_tick2;
        timer_tick_out ##1 timer_tick_out;
    endsequence
    property p_rst_idle;
        $fell(rst_in) |-> !s_axi_bvalid_out && !s_axi_rvalid_out
            && !expiry_out && !irq_out;
    endproperty
    property p_b_hold;
        s_axi_bvalid_out && !s_axi_bready_in
            |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
    endproperty
    property p_r_hold;
        s_axi_rvalid_out && !s_axi_rready_in
            |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
    endproperty
    property p_ar_block;
        s_axi_rvalid_out |-> !s_axi_arready_out;
    endproperty
    property p_w_answer;
        s_w_both |-> ##2 s_axi_bvalid_out;
    endproperty
    property p_r_answer;
        s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
    endproperty
    property p_exp_tick;
        expiry_out |-> $past(timer_tick_out);
    endproperty
    // accumulator step is below two thirds of the modulus, never three ticks
    property p_tick_density;
        s_tick2 |=> !timer_tick_out;
    endproperty
    property p_irq_src;
        $rose(irq_out) |-> expiry_out || $past(expiry_out)
            || s_axi_bvalid_out;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("outputs busy after reset");
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped early");
    a_ar_block: assert property (p_ar_block)
        else $error("read taken while answer pending");
    a_w_answer: assert property (p_w_answer)
        else $error("write response late");
    a_r_answer: assert property (p_r_answer)
        else $error("read response late");
    a_exp_tick: assert property (p_exp_tick)
        else $error("expiry without a tick");
    a_tick_density: assert property (p_tick_density)
        else $error("tick rate above base rate");
    a_irq_src: assert property (p_irq_src)
        else $error("interrupt without cause");
endmodule
`default_nettype wire

// file: sim/tb.sv
// self-checking bench for the frontend timer block
// assumes ftc_pkg, the field model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ftc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, tick, expiry, irq, fon, foff;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    int error_cnt = 0;
    int checks_done = 0;
    int per = 0;
    int tcnt = 0;
    int p, n, e;
    logic [7:0] ofs [4] = '{FTC_OFS_CTRL, FTC_OFS_PRESET, FTC_OFS_STATE,
        FTC_OFS_IRQ_MASK};
    always #20 clk = ~clk;
    ftc_timer dut (.sys_clk_in(clk), .rst_in(rst),
        .s_axi_awaddr_in(awaddr), .s_axi_awprot_in(3'h0),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
        .s_axi_arprot_in(3'h0), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .own_field_on_in(fon),
        .own_field_off_in(foff), .timer_tick_out(tick),
        .expiry_out(expiry), .irq_out(irq));
    ftc_field_model fm (.clk_in(clk), .field_on_out(fon),
        .field_off_out(foff));
    // ticks per period; a field event restarts the tally
    always @(negedge clk) begin
        if (fon | foff)
            tcnt = 0;
        else if (expiry) begin
            per = tcnt;
            tcnt = int'(tick);
        end else
            tcnt = tcnt + int'(tick);
    end
    // expected ticks in a window; divided rate halves per select step
    function automatic int erate(input int src, input int sel, input int w);
        int base;
        base = w * FTC_CONTACTLESS_INTERFACE_CLK_KHZ / FTC_SYS_CLK_KHZ;
        return src ? w * FTC_CONTACTLESS_INTERFACE_CLK_KHZ / (FTC_SYS_CLK_KHZ * (2 << sel))
            : base;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // write: both halves offered, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // ready sometimes late, so a waiting response is exercised
        bready <= 1'($urandom_range(1, 0));
        while (!(ad && wd)) begin
            @(negedge clk);
            ad = ad | (awvalid & awready);
            wd = wd | (wvalid & wready);
            @(posedge clk);
            if (ad)
                awvalid <= 1'b0;
            if (wd)
                wvalid <= 1'b0;
        end
        do @(negedge clk); while (bvalid !== 1'b1);
        r = bresp;
        if (!bready) begin
            @(posedge clk);
            bready <= 1'b1;
        end
        @(posedge clk);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        // ready sometimes late, so held read data is exercised
        rready <= 1'($urandom_range(1, 0));
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        if (!rready) begin
            @(posedge clk);
            rready <= 1'b1;
        end
        @(posedge clk);
        rready <= 1'b0;
    endtask
    task automatic wexp();
        do @(negedge clk); while (expiry !== 1'b1);
        @(negedge clk);
    endtask
    task automatic test_done();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // hang guard, well past the expected run length
    initial begin
        #(90000 * 40);
        error_cnt++;
        test_done();
    end
    initial begin
        void'($urandom(32'hc2b9));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // reset values, then an unmapped read and an unmapped write
        foreach (ofs[i]) begin
            rd(ofs[i]);
            chk(d, 32'h0);
        end
        rd(8'h18);
        chk(32'(r), 32'(FTC_RESP_SLVERR));
        wr(8'h1c, 32'h5);
        chk(32'(r), 32'(FTC_RESP_SLVERR));
        // tick rate, direct then every divided select
        wr(FTC_OFS_PRESET, 32'hfffff);
        for (int s = 0; s < 9; s++) begin
            wr(FTC_OFS_CTRL, (32'(s > 0) << FTC_BIT_SRC) | (32'h1 << FTC_BIT_NOW)
                | (32'(s > 0 ? s - 1 : 0) << FTC_BIT_RATE_LO));
            n = 0;
            repeat (4000) begin
                @(negedge clk);
                n = n + int'(tick);
            end
            e = erate(s > 0, s > 0 ? s - 1 : 0, 4000);
            checks_done++;
            if (n < e - 1 || n > e + 1) begin
                error_cnt++;
                $display("ERROR t=%0t got=%h exp=%h", $time, n, e);
            end
            wr(FTC_OFS_CTRL, 32'h1 << FTC_BIT_HALT);
        end
        // immediate start, one-shot stop and unmasked interrupt
        wr(FTC_OFS_PRESET, $urandom_range(99, 40));
        wr(FTC_OFS_IRQ_MASK, 32'h1);
        wr(FTC_OFS_CTRL, 32'h1 << FTC_BIT_NOW);
        rd(FTC_OFS_STATE);
        chk(d, 32'h1);
        wexp();
        chk(32'(irq), 32'h1);
        rd(FTC_OFS_COUNT);
        chk(d, 32'h0);
        rd(FTC_OFS_STATE);
        chk(d, 32'h0);
        wr(FTC_OFS_IRQ_STAT, 32'h1);
        @(negedge clk);
        chk(32'(irq), 32'h0);
        // own field events: wrong enable ignored, right one counts preset
        for (int v = 0; v < 2; v++) begin
            p = $urandom_range(9, 2);
            wr(FTC_OFS_PRESET, p);
            wr(FTC_OFS_CTRL, 32'h1 << (v ? FTC_BIT_OFF : FTC_BIT_ON));
            fm.pulse(v[0]);
            rd(FTC_OFS_STATE);
            chk(d, 32'h0);
            wr(FTC_OFS_CTRL, 32'h1 << (v ? FTC_BIT_ON : FTC_BIT_OFF));
            fm.pulse(v[0]);
            wexp();
            chk(per, p);
        end
        // reload keeps the period with the interrupt masked
        p = $urandom_range(9, 2);
        wr(FTC_OFS_IRQ_MASK, 32'h0);
        // field runs left the flag set; clear it so reload must set it
        wr(FTC_OFS_IRQ_STAT, 32'h1);
        wr(FTC_OFS_PRESET, p);
        wr(FTC_OFS_CTRL, (32'h1 << FTC_BIT_NOW) | (32'h1 << FTC_BIT_RELOAD));
        wexp();
        wexp();
        chk(per, p);
        rd(FTC_OFS_STATE);
        chk(d, 32'h1);
        rd(FTC_OFS_IRQ_STAT);
        chk(d, 32'h1);
        chk(32'(irq), 32'h0);
        wr(FTC_OFS_CTRL, 32'h1 << FTC_BIT_HALT);
        test_done();
    end
endmodule
bind ftc_timer ftc_timer_asserts chk_i (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out),
    .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in), .timer_tick_out(timer_tick_out),
    .expiry_out(expiry_out), .irq_out(irq_out));
`default_nettype wire
